// >>> core/ssq_pkg.sv
package ssq_pkg;

  // ----------------------------------------------------------------
  // register map (word aligned byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_CMD      = 8'h04;
  localparam logic [7:0] ADDR_INTERVAL = 8'h08;
  localparam logic [7:0] ADDR_DELAY    = 8'h0C;
  localparam logic [7:0] ADDR_LIST0    = 8'h10;
  localparam logic [7:0] ADDR_LIST1    = 8'h14;
  localparam logic [7:0] ADDR_LIST2    = 8'h18;
  localparam logic [7:0] ADDR_STATUS   = 8'h1C;
  localparam logic [7:0] ADDR_TOT      = 8'h20;
  localparam logic [7:0] ADDR_TOT_CLR  = 8'h24;
  localparam logic [7:0] ADDR_DIG      = 8'h28;
  localparam logic [7:0] ADDR_MIDX     = 8'h2C;
  localparam logic [7:0] ADDR_MVAL     = 8'h30;
  localparam logic [7:0] ADDR_MSTAMP   = 8'h34;

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  localparam int CTRL_W        = 11;
  localparam int CTL_SRC_LSB   = 0;   // 3 bits, trigger source
  localparam int CTL_TOT_FALL  = 3;   // totalizer counts falling edges
  localparam int CTL_AUTORANGE = 4;
  localparam int CTL_RES_LSB   = 5;   // 3 bits, resolution / speed
  localparam int CTL_COMBINE   = 8;   // ports read as one 16-bit word
  localparam int CTL_EXT_SYNC  = 9;   // external instrument measures
  localparam logic [CTRL_W-1:0] CTRL_RESET = 11'h010;

  localparam int CMD_INIT = 0;
  localparam int CMD_STOP = 1;
  localparam int CMD_SWTRIG = 2;

  // trigger sources
  localparam logic [2:0] SRC_INTERVAL = 3'h0;
  localparam logic [2:0] SRC_MANUAL   = 3'h1;
  localparam logic [2:0] SRC_SOFTWARE = 3'h2;
  localparam logic [2:0] SRC_EXTERNAL = 3'h3;
  localparam logic [2:0] SRC_ALARM    = 3'h4;

  // ----------------------------------------------------------------
  // channel space: slot index * 32 + channel, slots 100/200/300
  // ----------------------------------------------------------------
  localparam int          NCH       = 96;
  localparam logic [6:0]  CH_END    = 7'h60;
  localparam logic [6:0]  CH_PORT_A = 7'h41;
  localparam logic [6:0]  CH_PORT_B = 7'h42;
  localparam logic [6:0]  CH_TOT    = 7'h43;

  // ----------------------------------------------------------------
  // storage and counters
  // ----------------------------------------------------------------
  localparam int           MEM_DEPTH = 50000;
  localparam logic [15:0]  MEM_LAST  = 16'hC34F;   // depth - 1
  localparam int           TOT_W     = 26;
  localparam logic [25:0]  TOT_MAX   = 26'h3FFFFFF;
  localparam int           CLK_MHZ   = 100;
  localparam int           TOT_MAX_KHZ = 100;      // highest pulse rate

  typedef enum logic [2:0] {
    ST_IDLE, ST_FIND, ST_SETTLE, ST_MEAS, ST_STORE, ST_STEP
  } ssq_st_t;

  typedef struct packed {
    logic             route_en;
    logic [6:0]       route_chan;
    logic             meas_start;
    logic             chan_closed;
    logic             autorange;
    logic [2:0]       res_sel;
  } ssq_fe_t;

  typedef struct packed {
    ssq_st_t          st;
    logic             busy;
    logic             armed;
    logic             first;
    logic [6:0]       chan;
    logic [31:0]      dly;
    logic [31:0]      ivl;
    logic [31:0]      ts;
    logic [31:0]      val;
    logic [15:0]      wp;
    logic [15:0]      cnt;
    logic             full;
    logic [TOT_W-1:0] tot;
    logic             tot_prev;
    logic [CTRL_W-1:0] ctrl;
    logic [31:0]      ivl_set;
    logic [31:0]      dly_set;
    logic [NCH-1:0]   list;
    logic [15:0]      midx;
    logic [31:0]      rdata;
    ssq_fe_t          fe;
  } ssq_state_t;

endpackage

// >>> core/ssq_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - sweep visits channels in ascending order
// - unlisted channels skipped, measure only scanning
// - one routed channel, one measurement each
// - store readings while scanning, time stamped
// - new scan discards previous readings
// - interval timer launches sweeps periodically
// - programmable delay between channels
// - manual key advances one step
// - software command starts sweep
// - external TTL pulse starts sweep
// - logged alarm starts sweep
// - scan may read ports or totalizer
// - two lines sync with external instrument
// - two 8-bit ports, live or scanned
// - ports combine into one 16-bit word
// - 26-bit totalizer, manual or scanned read
// - totalizer edge selectable rising/falling
// - totalizer wraps to zero past maximum
// - plain read, or read-and-reset losing nothing
// - autorange or fixed range passed to front end
// - resolution/speed selection passed to front end
// - full storage flags and overwrites oldest
module ssq_top
  import ssq_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  output logic             route_en,
  output logic      [6:0]  route_chan,
  output logic             meas_start,
  input  wire logic        meas_done,
  input  wire logic [23:0] meas_data,
  output logic             autorange,
  output logic      [2:0]  res_sel,
  output logic             chan_closed,
  input  wire logic        ext_meas_done,
  input  wire logic        ext_trig,
  input  wire logic        alarm_logged,
  input  wire logic        scan_key,
  input  wire logic [7:0]  port_a,
  input  wire logic [7:0]  port_b,
  input  wire logic        tot_in,
  output logic             scanning,
  output logic             sweep_busy,
  output logic             mem_full
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_q;
  logic       rst_sync_b;

  // two-stage release of the asynchronous reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_sync_b = rst_q[1];

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // circular storage index, wraps at the depth
  function automatic logic [15:0] wrap_add(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] sum;
    sum = {1'b0, a} + {1'b0, b};
    if (sum > {1'b0, MEM_LAST}) begin
      sum = sum - 17'(MEM_DEPTH);
    end
    return sum[15:0];
  endfunction

  // value of a multifunction channel, read without the analog front end
  function automatic logic [31:0] mf_value(input logic [6:0] ch, input logic comb,
                                           input logic [7:0] pa, input logic [7:0] pb,
                                           input logic [TOT_W-1:0] tc);
    if (ch == CH_TOT) begin
      return {6'h00, tc};
    end else if (comb) begin
      return {16'h0000, pb, pa};
    end else if (ch == CH_PORT_B) begin
      return {24'h000000, pb};
    end else begin
      return {24'h000000, pa};
    end
  endfunction

  function automatic logic is_mf(input logic [6:0] ch);
    return (ch == CH_PORT_A) || (ch == CH_PORT_B) || (ch == CH_TOT);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ssq_state_t s;
  ssq_state_t next_s;
  logic [31:0] mem_val [0:MEM_DEPTH-1];
  logic [31:0] mem_ts  [0:MEM_DEPTH-1];
  logic        tot_edge;
  logic        trig;
  logic        meas_ok;
  logic [2:0]  src;
  logic [15:0] ridx;
  logic        wr_cmd;

  assign src      = s.ctrl[CTL_SRC_LSB +: 3];
  assign tot_edge = s.ctrl[CTL_TOT_FALL] ? (s.tot_prev & ~tot_in)
                                         : (~s.tot_prev & tot_in);
  assign meas_ok  = s.ctrl[CTL_EXT_SYNC] ? ext_meas_done : meas_done;
  assign ridx     = wrap_add(s.full ? s.wp : 16'h0000, s.midx);
  assign wr_cmd   = wr && (addr == ADDR_CMD);

  // sweep launch by the selected source
  always_comb begin
    case (src)
      SRC_INTERVAL: trig = (s.ivl == 32'h0);
      SRC_MANUAL:   trig = scan_key;
      SRC_SOFTWARE: trig = wr_cmd && wdata[CMD_SWTRIG];
      SRC_EXTERNAL: trig = ext_trig;
      SRC_ALARM:    trig = alarm_logged;
      default:      trig = 1'b0;
    endcase
  end

  // next state of the whole block
  always_comb begin
    next_s = s;
    next_s.fe.meas_start  = 1'b0;
    next_s.fe.chan_closed = 1'b0;
    next_s.ts             = s.ts + 32'h1;
    next_s.tot_prev       = tot_in;
    next_s.tot            = s.tot + {25'h0, tot_edge};
    next_s.fe.autorange   = s.ctrl[CTL_AUTORANGE];
    next_s.fe.res_sel     = s.ctrl[CTL_RES_LSB +: 3];

    // interval timer reloads after each expiry while armed
    if (s.armed && src == SRC_INTERVAL) begin
      next_s.ivl = (s.ivl == 32'h0) ? s.ivl_set : s.ivl - 32'h1;
    end

    // register reads, answered one cycle later
    if (rd) begin
      if (addr == ADDR_CTRL) begin
        next_s.rdata = {21'h0, s.ctrl};
      end else if (addr == ADDR_INTERVAL) begin
        next_s.rdata = s.ivl_set;
      end else if (addr == ADDR_DELAY) begin
        next_s.rdata = s.dly_set;
      end else if (addr == ADDR_LIST0) begin
        next_s.rdata = s.list[31:0];
      end else if (addr == ADDR_LIST1) begin
        next_s.rdata = s.list[63:32];
      end else if (addr == ADDR_LIST2) begin
        next_s.rdata = s.list[95:64];
      end else if (addr == ADDR_STATUS) begin
        next_s.rdata = {s.cnt, 13'h0, s.full, s.st != ST_IDLE, s.armed};
      end else if (addr == ADDR_TOT) begin
        next_s.rdata = {6'h00, s.tot};
      end else if (addr == ADDR_TOT_CLR) begin
        next_s.rdata = {6'h00, s.tot};
        next_s.tot   = {25'h0, tot_edge};
      end else if (addr == ADDR_DIG) begin
        next_s.rdata = mf_value(CH_PORT_A, 1'b1, port_a, port_b, s.tot);
      end else if (addr == ADDR_MIDX) begin
        next_s.rdata = {16'h0, s.midx};
      end else if (addr == ADDR_MVAL) begin
        next_s.rdata = mem_val[ridx];
      end else if (addr == ADDR_MSTAMP) begin
        next_s.rdata = mem_ts[ridx];
      end else begin
        next_s.rdata = 32'h0;
      end
    end

    // register writes
    if (wr) begin
      if (addr == ADDR_CTRL) begin
        next_s.ctrl = wdata[CTRL_W-1:0];
      end else if (addr == ADDR_INTERVAL) begin
        next_s.ivl_set = wdata;
      end else if (addr == ADDR_DELAY) begin
        next_s.dly_set = wdata;
      end else if (addr == ADDR_LIST0) begin
        next_s.list[31:0] = wdata;
      end else if (addr == ADDR_LIST1) begin
        next_s.list[63:32] = wdata;
      end else if (addr == ADDR_LIST2) begin
        next_s.list[95:64] = wdata;
      end else if (addr == ADDR_MIDX) begin
        next_s.midx = wdata[15:0];
      end
    end

    // sweep sequencer
    case (s.st)
      ST_IDLE: begin
        if (s.armed && trig) begin
          next_s.st    = ST_FIND;
          next_s.chan  = 7'h00;
          next_s.first = 1'b1;
        end
      end
      ST_FIND: begin
        if (s.chan == CH_END) begin
          next_s.st = ST_IDLE;
        end else if (s.list[s.chan]) begin
          next_s.st            = ST_SETTLE;
          next_s.fe.route_en   = 1'b1;
          next_s.fe.route_chan = s.chan;
          next_s.dly           = s.first ? 32'h0 : s.dly_set;
        end else begin
          next_s.chan = s.chan + 7'h01;
        end
      end
      ST_SETTLE: begin
        if (s.dly != 32'h0) begin
          next_s.dly = s.dly - 32'h1;
        end else if (is_mf(s.chan)) begin
          next_s.val = mf_value(s.chan, s.ctrl[CTL_COMBINE], port_a, port_b,
                                s.tot);
          next_s.st  = ST_STORE;
        end else begin
          next_s.fe.meas_start  = ~s.ctrl[CTL_EXT_SYNC];
          next_s.fe.chan_closed = 1'b1;
          next_s.st             = ST_MEAS;
        end
      end
      ST_MEAS: begin
        if (meas_ok) begin
          next_s.val = {8'h00, meas_data};
          next_s.st  = ST_STORE;
        end
      end
      ST_STORE: begin
        next_s.wp          = (s.wp == MEM_LAST) ? 16'h0 : s.wp + 16'h1;
        next_s.cnt         = (s.cnt == MEM_LAST + 16'h1) ? s.cnt : s.cnt + 16'h1;
        next_s.full        = s.full || (s.cnt == MEM_LAST);
        next_s.fe.route_en = 1'b0;
        next_s.chan        = s.chan + 7'h01;
        next_s.first       = 1'b0;
        next_s.st          = (src == SRC_MANUAL) ? ST_STEP : ST_FIND;
      end
      ST_STEP: begin
        if (scan_key) begin
          next_s.st = ST_FIND;
        end
      end
      default: begin
        next_s.st = ST_IDLE;
      end
    endcase

    // scan start clears storage; stop drops everything in flight except the meas_start/chan_closed pulses or store of that cycle
    if (wr_cmd && wdata[CMD_INIT]) begin
      next_s.armed = 1'b1;
      next_s.wp    = 16'h0;
      next_s.cnt   = 16'h0;
      next_s.full  = 1'b0;
      next_s.ivl   = s.ivl_set;
      next_s.st    = ST_IDLE;
      next_s.fe.route_en = 1'b0;
    end
    if (wr_cmd && wdata[CMD_STOP]) begin
      next_s.armed       = 1'b0;
      next_s.st          = ST_IDLE;
      next_s.fe.route_en = 1'b0;
    end
    // busy kept beside the state so the output leaves a flop
    next_s.busy = (next_s.st != ST_IDLE);
  end

  // state register
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      s      <= '0;
      s.st   <= ST_IDLE;
      s.ctrl <= CTRL_RESET;
      s.fe.autorange <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // reading storage, written only in the store step of an armed scan
  always_ff @(posedge clk) begin
    if (s.st == ST_STORE && s.armed) begin
      mem_val[s.wp] <= s.val;
      mem_ts[s.wp]  <= s.ts;
    end
  end

  // outputs
  assign rdata       = s.rdata;
  assign route_en    = s.fe.route_en;
  assign route_chan  = s.fe.route_chan;
  assign meas_start  = s.fe.meas_start;
  assign chan_closed = s.fe.chan_closed;
  assign autorange   = s.fe.autorange;
  assign res_sel     = s.fe.res_sel;
  assign scanning    = s.armed;
  assign sweep_busy  = s.busy;
  assign mem_full    = s.full;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_b);

  sequence meas_issued;
    s.fe.meas_start ##1 (s.st == ST_MEAS);
  endsequence

  sequence ivl_expired;
    s.armed && src == SRC_INTERVAL && s.ivl == 32'h0 && s.st == ST_IDLE && !wr_cmd;
  endsequence

  a_meas_listed_only: assert property (s.fe.meas_start
                                       |-> s.armed && s.list[s.chan] && s.fe.route_en)
    else $error("measurement outside scan or on unlisted channel");
  a_meas_one_chan: assert property (meas_issued
                                    |-> s.fe.route_chan == $past(s.chan, 2) && s.fe.route_en)
    else $error("measurement not on the single routed channel");
  a_ascend_step: assert property ((s.st == ST_STORE && !wr_cmd)
                                  |=> s.chan == $past(s.chan) + 7'h01)
    else $error("sweep did not advance to the next channel");
  a_init_clears: assert property ((wr_cmd && wdata[CMD_INIT])
                                  |=> s.cnt == 16'h0 && !s.full && s.armed)
    else $error("scan start did not clear storage");
  a_tot_wrap: assert property ((s.tot == TOT_MAX && tot_edge && !rd)
                               |=> s.tot == 26'h0)
    else $error("totalizer did not wrap to zero");
  a_tot_clear: assert property ((rd && addr == ADDR_TOT_CLR)
                                |=> s.rdata == {6'h00, $past(s.tot)}
                                    && s.tot == {25'h0, $past(tot_edge)})
    else $error("read-and-reset lost a count or returned a wrong value");
  a_busy_ignore: assert property ((s.st == ST_MEAS && trig && !meas_ok && !wr_cmd)
                                  |=> s.st == ST_MEAS && s.chan == $past(s.chan))
    else $error("trigger disturbed a sweep in progress");
  a_full_flag: assert property ((s.st == ST_STORE && s.cnt == MEM_LAST && !wr_cmd)
                                |=> s.full ##1 s.full)
    else $error("full flag not raised when storage filled");
  a_delay_hold: assert property ((s.st == ST_SETTLE && s.dly != 32'h0 && !wr_cmd)
                                 |=> s.st == ST_SETTLE && !s.fe.meas_start)
    else $error("measurement taken before channel delay ran out");
  a_swtrig_start: assert property ((s.armed && s.st == ST_IDLE && src == SRC_SOFTWARE
                                    && wr_cmd && wdata[CMD_SWTRIG] && !wdata[CMD_STOP]
                                    && !wdata[CMD_INIT])
                                   |=> s.st == ST_FIND && s.chan == 7'h00)
    else $error("software command did not start a sweep");
  a_ivl_start: assert property (ivl_expired |=> s.st == ST_FIND && s.chan == 7'h00)
    else $error("interval expiry did not start a sweep");
  a_step_wait: assert property ((s.st == ST_STEP && !scan_key && !wr_cmd)
                                |=> s.st == ST_STEP && !s.fe.meas_start)
    else $error("manual scan advanced without a key press");
  a_store_armed: assert property (s.st == ST_STORE |-> s.armed)
    else $error("reading stored outside an active scan");

endmodule

// >>> sim/ssq_inst_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// front end and external instrument model
// ----------------------------------------------------------------
module ssq_inst_model (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        meas_start,
  input  wire logic        chan_closed,
  input  wire logic [3:0]  lat,
  output logic             meas_done,
  output logic      [23:0] meas_data,
  output logic             ext_meas_done
);
  int          cnt_m;
  int          cnt_x;
  logic [23:0] seq;

  // answer each request lat + 1 cycles after it is sampled with a one-cycle done pulse
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_m         <= 0;
      cnt_x         <= 0;
      seq           <= 24'h000100;
      meas_done     <= 1'b0;
      ext_meas_done <= 1'b0;
      meas_data     <= 24'h5A5A5A;
    end else begin
      meas_done     <= 1'b0;
      ext_meas_done <= 1'b0;
      meas_data     <= ~meas_data;              // data not held outside done
      if (meas_start) begin
        cnt_m <= int'(lat) + 1;
      end else if (cnt_m > 1) begin
        cnt_m <= cnt_m - 1;
      end else if (cnt_m == 1) begin
        cnt_m     <= 0;
        meas_done <= 1'b1;
        meas_data <= seq;
        seq       <= seq + 24'h000001;
      end
      // instrument measures once per closed channel
      if (chan_closed) begin
        cnt_x <= int'(lat) + 1;
      end else if (cnt_x > 1) begin
        cnt_x <= cnt_x - 1;
      end else if (cnt_x == 1) begin
        cnt_x         <= 0;
        ext_meas_done <= 1'b1;
      end
    end
  end
endmodule

// >>> sim/ssq_top_tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, gt) \
  begin \
    n_compared++; \
    if ((gt) !== (ex)) begin \
      n_errors++; \
      $display("BAD %s exp %0h got %0h", nm, ex, gt); \
    end \
  end
module ssq_top_tb
  import ssq_pkg::*;
;
  logic        clk, rst_b, wr, rd, meas_done, ext_meas_done, ext_trig;
  logic        alarm_logged, scan_key, tot_in, route_en, meas_start;
  logic        autorange, chan_closed, scanning, sweep_busy, mem_full;
  logic [7:0]  addr, port_a, port_b;
  logic [31:0] wdata, rdata;
  logic [6:0]  route_chan;
  logic [23:0] meas_data;
  logic [2:0]  res_sel;
  logic [3:0]  lat;
  int          n_errors, n_compared, cyc, n_closed;
  logic [6:0]  chans[$];
  int          times[$];

  ssq_top dut (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .route_en(route_en), .route_chan(route_chan),
    .meas_start(meas_start), .meas_done(meas_done), .meas_data(meas_data),
    .autorange(autorange), .res_sel(res_sel), .chan_closed(chan_closed),
    .ext_meas_done(ext_meas_done), .ext_trig(ext_trig),
    .alarm_logged(alarm_logged), .scan_key(scan_key), .port_a(port_a),
    .port_b(port_b), .tot_in(tot_in), .scanning(scanning),
    .sweep_busy(sweep_busy), .mem_full(mem_full));

  ssq_inst_model partner (
    .clk(clk), .rst_b(rst_b), .meas_start(meas_start),
    .chan_closed(chan_closed), .lat(lat), .meas_done(meas_done),
    .meas_data(meas_data), .ext_meas_done(ext_meas_done));

  // ----------------------------------------------------------------
  // clock, cycle count and measurement log
  // ----------------------------------------------------------------
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (chan_closed === 1'b1) begin
      n_closed <= n_closed + 1;
    end
    if (meas_start === 1'b1) begin
      chans.push_back(route_chan);
      times.push_back(cyc);
    end
  end

  // ----------------------------------------------------------------
  // bus tasks and helpers
  // ----------------------------------------------------------------
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    repeat (4) @(posedge clk);
    while (sweep_busy !== 1'b0 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    `CHK("sweep_end", 1'b1, k < 3000)
  endtask

  task automatic chk_count(input logic [15:0] e);
    logic [31:0] d;
    rd_reg(ADDR_STATUS, d);
    `CHK("stored", e, d[31:16])
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd_reg(a, d);
    `CHK("reg", e, d)
  endtask

  task automatic sw_sweep(output int g);
    times.delete();
    wr_reg(ADDR_CMD, 32'h00000004);
    wait_idle();
    g = times[1] - times[0];
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd_chk(ADDR_CTRL, 32'h00000010);
    `CHK("autorange_rst", 1'b1, autorange)
    wr_reg(ADDR_CTRL, 32'h000000A2);
    repeat (2) @(posedge clk);
    `CHK("autorange", 1'b0, autorange)
    `CHK("res_sel", 3'h5, res_sel)
  endtask

  task automatic t_tot();
    wr_reg(ADDR_CTRL, 32'h00000010);
    repeat (3) begin
      @(posedge clk);
      tot_in <= 1'b1;
      @(posedge clk);
      tot_in <= 1'b0;
    end
    repeat (3) @(posedge clk);
    rd_chk(ADDR_TOT, 32'h00000003);
    rd_chk(ADDR_TOT, 32'h00000003);
    rd_chk(ADDR_TOT_CLR, 32'h00000003);
    rd_chk(ADDR_TOT, 32'h00000000);
    wr_reg(ADDR_CTRL, 32'h00000018);
    tot_in <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(ADDR_TOT, 32'h00000000);
    tot_in <= 1'b0;
    repeat (3) @(posedge clk);
    rd_chk(ADDR_TOT, 32'h00000001);
    rd_chk(ADDR_DIG, {16'h0000, port_b, port_a});
  endtask

  task automatic t_sweep();
    logic [31:0] s0, s1, v;
    lat = 4'h6;
    wr_reg(ADDR_LIST0, 32'h0000000A);           // channels 1 and 3
    wr_reg(ADDR_LIST2, 32'h0000000A);           // port A and totalizer
    wr_reg(ADDR_CTRL, 32'h00000012);
    wr_reg(ADDR_CMD, 32'h00000001);
    repeat (20) @(posedge clk);
    chk_count(16'h0000);
    `CHK("scanning", 1'b1, scanning)
    chans.delete();
    wr_reg(ADDR_CMD, 32'h00000004);
    repeat (6) @(posedge clk);
    `CHK("busy", 1'b1, sweep_busy)
    `CHK("routed", 1'b1, route_en)
    wr_reg(ADDR_CMD, 32'h00000004);
    wait_idle();
    `CHK("n_meas", 2, chans.size())
    `CHK("first", 7'h01, chans[0])
    `CHK("second", 7'h03, chans[1])
    chk_count(16'h0004);
    `CHK("route_off", 1'b0, route_en)
    `CHK("mem_full", 1'b0, mem_full)
    wr_reg(ADDR_MIDX, 32'h00000002);
    rd_reg(ADDR_MVAL, v);
    `CHK("port_entry", port_a, v[7:0])
    wr_reg(ADDR_MIDX, 32'h00000003);
    rd_reg(ADDR_MVAL, v);
    `CHK("tot_entry", 32'h00000001, v)
    wr_reg(ADDR_MIDX, 32'h00000000);
    rd_reg(ADDR_MSTAMP, s0);
    rd_reg(ADDR_MVAL, v);
    `CHK("reading", 32'h00000100, v)
    wr_reg(ADDR_MIDX, 32'h00000001);
    rd_reg(ADDR_MSTAMP, s1);
    `CHK("stamp_order", 1'b1, s1 > s0)
    wr_reg(ADDR_CMD, 32'h00000001);
    chk_count(16'h0000);
  endtask

  task automatic t_delay();
    int g0, g5;
    lat = 4'h2;
    wr_reg(ADDR_LIST2, 32'h00000000);
    wr_reg(ADDR_DELAY, 32'h00000000);
    sw_sweep(g0);
    wr_reg(ADDR_DELAY, 32'h00000005);
    sw_sweep(g5);
    `CHK("delay_gap", 5, g5 - g0)
  endtask

  task automatic t_sync();
    int n, m;
    wr_reg(ADDR_CTRL, 32'h00000212);
    wr_reg(ADDR_CMD, 32'h00000001);
    n = times.size();
    m = n_closed;
    wr_reg(ADDR_CMD, 32'h00000004);
    wait_idle();
    chk_count(16'h0002);
    `CHK("no_meas_start", n, times.size())
    `CHK("closed", m + 2, n_closed)
  endtask

  task automatic t_sources();
    logic [2:0] srcs[3];
    srcs = '{SRC_MANUAL, SRC_EXTERNAL, SRC_ALARM};
    wr_reg(ADDR_LIST0, 32'h00000000);
    wr_reg(ADDR_LIST2, 32'h80000000);           // channel 95 only
    foreach (srcs[i]) begin
      wr_reg(ADDR_CTRL, {29'h00000002, srcs[i]});
      wr_reg(ADDR_CMD, 32'h00000001);
      repeat (20) @(posedge clk);
      chk_count(16'h0000);
      @(posedge clk);
      scan_key     <= (i == 0);
      ext_trig     <= (i == 1);
      alarm_logged <= (i == 2);
      @(posedge clk);
      scan_key     <= 1'b0;
      ext_trig     <= 1'b0;
      alarm_logged <= 1'b0;
      if (i == 0) begin
        // manual mode holds after each stored channel until the next press
        repeat (150) @(posedge clk);
        `CHK("step_wait", 1'b1, sweep_busy)
        chk_count(16'h0001);
        @(posedge clk);
        scan_key <= 1'b1;
        @(posedge clk);
        scan_key <= 1'b0;
      end
      wait_idle();
      chk_count(16'h0001);
    end
  endtask

  task automatic t_interval();
    int n;
    wr_reg(ADDR_CTRL, 32'h00000010);
    wr_reg(ADDR_INTERVAL, 32'h000000C7);
    wr_reg(ADDR_CMD, 32'h00000001);
    times.delete();
    repeat (700) @(posedge clk);
    `CHK("sweeps", 1'b1, times.size() >= 3)
    `CHK("period", 200, times[2] - times[1])
    wr_reg(ADDR_CMD, 32'h00000002);
    n = times.size();
    repeat (300) @(posedge clk);
    `CHK("stopped", 1'b0, scanning)
    `CHK("idle_after_stop", n, times.size())
  endtask

  task print_verdict();
    if (n_errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    {clk, rst_b, wr, rd, ext_trig, alarm_logged, scan_key, tot_in} = '0;
    {addr, wdata, n_errors, n_compared, cyc, n_closed} = '0;
    port_a = 8'hC3;
    port_b = 8'h5E;
    lat    = 4'h2;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_tot();
    t_sweep();
    t_delay();
    t_sync();
    t_sources();
    t_interval();
    print_verdict();
  end

  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    print_verdict();
  end
endmodule
